/* core/ish_host_port.v */
// ISA slave host port with DMA write FIFO and reset/strap handling
`timescale 1ns/10ps
`default_nettype none
`include "ish_host_port_regs.vh"

// How it works
// RULE1 - Low twelve address bits pick an internal block by its configured base.
// RULE2 - With upper pins as address, decode only when all four are zero.
// RULE3 - Eight-bit data bus, driven only on reads, sampled on writes.
// RULE4 - Host holds AEN low for I/O cycles, high for DMA cycles.
// RULE5 - Low read strobe starts a register read or DMA data read.
// RULE6 - Low write strobe starts a register write or DMA data write.
// RULE7 - Ready line pulled low while an access cannot finish yet.
// RULE8 - Host stretches the cycle while the ready line stays low.
// RULE9 - DMA request stays high until every byte of the unit moved.
// RULE10 - DMA channels are byte wide; each transfer carries eight bits.
// RULE11 - DMA pairs default to system channels 0, 1, 3; mapping is loadable.
// RULE12 - On acknowledge, latch bus data for writes, drive data for reads.
// RULE13 - Each interrupt line enabled individually, signals events to service.
// RULE14 - Interrupt lines default to 5,7,9,11,12,15, seventh unconnected.
// RULE15 - While reset drive is high, all logic is reset and powered down; strap latches and edge history reset only on sys_rst.
// RULE16 - Falling reset drive latches CDROM-mode, port-select and clock straps.
// RULE17 - Buffered reset output held low while reset drive is high.
// RULE18 - System asserts reset drive at every power-up.
// RULE19 - Config port 0x279, else 0x308 or 0x388 by clock strap.
// RULE20 - CDROM strap high makes shared pins upper address inputs.
// RULE21 - Host waits about 200 ms after reset drive falls before writing.
// RULE22 - I/O decode ignored while AEN high; only acknowledged DMA served.
// RULE23 - Data bus undriven except decoded read or acknowledged DMA read.

// Plain FIFO with valid/ready on both sides
module ish_fifo #(
  parameter W     = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire          clk,
  input  wire          rst,
  input  wire [W-1:0]  in_data,
  input  wire          in_valid,
  output wire          in_ready,
  output wire [W-1:0]  out_data,
  output wire          out_valid,
  input  wire          out_ready
);
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0]   cnt_ff;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage writes, no reset needed
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill count
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff    <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                     : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                     : rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// Top: strobe-timed ISA slave port
module ish_host_port #(
  parameter NBLK     = 4,
  parameter SPAN     = 4,
  parameter FDEPTH   = 8,
  parameter FAW      = 3,
  parameter INIT_CYC = `ISH_INIT_CYC
) (
  input  wire                clk,
  input  wire                sys_rst,
  input  wire [11:0]         sa_low,
  input  wire [3:0]          upper_address_pins,
  input  wire                aen,
  input  wire                ior_n,
  input  wire                iow_n,
  input  wire [7:0]          sd_in,
  output wire [7:0]          sd_out,
  output wire                sd_oe,
  output wire                iochrdy_out,
  output wire                iochrdy_oe,
  output reg  [2:0]          dma_request_lines,
  input  wire [2:0]          dma_ack_lines_n,
  output wire [6:0]          irq_lines,
  input  wire                resdrv,
  input  wire                cdrom_mode_strap,
  input  wire                port_select_strap,
  input  wire                clock_strap,
  output wire                buffered_reset_out_n,
  output wire                power_down,
  output reg                 cdrom_mode_ff,
  output reg  [11:0]         cfg_port_ff,
  output reg                 dev_ready_ff,
  input  wire [NBLK*12-1:0]  cfg_base,
  input  wire [NBLK-1:0]     cfg_blk_en,
  input  wire [2:0]          dma_chan_en,
  input  wire [6:0]          irq_en,
  input  wire [6:0]          irq_event,
  input  wire                hw_cfg_load,
  input  wire [5:0]          hw_dma_map,
  input  wire [27:0]         hw_irq_map,
  output reg  [5:0]          dma_map_ff,
  output reg  [27:0]         irq_map_ff,
  output reg                 reg_rd_req_ff,
  output reg                 reg_wr_req_ff,
  output reg  [1:0]          reg_blk_ff,
  output reg  [11:0]         reg_addr_ff,
  output reg  [7:0]          reg_wdata_ff,
  input  wire [7:0]          reg_rdata,
  input  wire                reg_rdata_valid,
  input  wire [2:0]          dma_need,
  input  wire [8:0]          dma_unit_bytes,
  output reg                 dma_rd_req_ff,
  output reg  [1:0]          dma_rd_chan_ff,
  input  wire [7:0]          dma_rd_data,
  input  wire                dma_rd_valid,
  output wire [7:0]          dma_wr_data,
  output wire                dma_wr_valid,
  input  wire                dma_wr_ready
);
  // One-hot cycle states
  localparam S_IDLE  = 5'h01;
  localparam S_RWAIT = 5'h02;
  localparam S_DWAIT = 5'h04;
  localparam S_PWAIT = 5'h08;
  localparam S_HOLD  = 5'h10;

  reg  [4:0]  state_ff;
  reg  [4:0]  nxt_state;
  reg         ior_q_ff;
  reg         iow_q_ff;
  reg         resdrv_q_ff;
  reg  [7:0]  sd_out_ff;
  reg         drive_ff;
  reg         wait_ff;
  reg  [31:0] init_cnt_ff;
  reg  [2:0]  bytes_ff [0:2];
  reg  [2:0]  need_q_ff;
  wire        rst;
  wire        rd_fall;
  wire        wr_fall;
  wire        upper_ok;
  wire        io_hit;
  wire [1:0]  hit_blk;
  wire [2:0]  ack_act;
  wire        dma_cyc;
  wire [1:0]  ack_ch;
  wire        fifo_in_ready;
  reg         fifo_push;
  integer     i;

  // Block base match for one window
  function blk_match;
    input [11:0] addr;
    input [11:0] base;
    begin
      blk_match = ((addr >> SPAN) == (base >> SPAN));
    end
  endfunction

  // Lowest set bit of a three-bit vector
  function [1:0] low_idx3;
    input [2:0] v;
    begin
      low_idx3 = v[0] ? 2'h0 : (v[1] ? 2'h1 : 2'h2);
    end
  endfunction

  // Lowest matching block index, plus any-hit flag
  reg  [1:0] hit_idx;
  reg        hit_any;
  always @* begin
    hit_idx = 2'h0;
    hit_any = 1'b0;
    for (i = NBLK - 1; i >= 0; i = i - 1) begin
      if (cfg_blk_en[i] && blk_match(sa_low, cfg_base[i*12 +: 12])) begin
        hit_idx = i[1:0]; // see RULE1
        hit_any = 1'b1;
      end
    end
  end

  assign rst      = sys_rst | resdrv; // see RULE15
  assign rd_fall  = ior_q_ff & ~ior_n;
  assign wr_fall  = iow_q_ff & ~iow_n;
  // Upper pins qualify only in address mode
  assign upper_ok = ~cdrom_mode_ff |
                    (upper_address_pins == `ISH_UPPER_ZERO); // see RULE2
  assign io_hit   = hit_any & upper_ok & ~aen; // see RULE22
  assign hit_blk  = hit_idx;
  assign ack_act  = ~dma_ack_lines_n & dma_chan_en & dma_request_lines;
  assign dma_cyc  = aen & (ack_act != 3'h0); // see RULE22
  assign ack_ch   = low_idx3(ack_act);

  // Bus pins: data only while serving a read, ready open drain
  assign sd_out      = sd_out_ff;
  assign sd_oe       = drive_ff & ~ior_n; // see RULE23
  assign iochrdy_out = 1'b0;
  assign iochrdy_oe  = wait_ff; // see RULE7
  assign buffered_reset_out_n = ~resdrv; // see RULE17
  assign power_down  = resdrv; // see RULE15
  assign irq_lines   = irq_event & irq_en; // see RULE13

  // Edge history of strobes and reset drive
  always @(posedge clk) begin
    if (sys_rst) begin
      ior_q_ff    <= 1'b1;
      iow_q_ff    <= 1'b1;
      resdrv_q_ff <= 1'b0; // Idle level, no false fall after reset
    end else begin
      ior_q_ff    <= ior_n;
      iow_q_ff    <= iow_n;
      resdrv_q_ff <= resdrv;
    end
  end

  // Straps caught on falling reset drive, port picked from them
  always @(posedge clk) begin
    if (sys_rst) begin
      cdrom_mode_ff <= `ISH_STRAP_RST;
      cfg_port_ff   <= `ISH_CFG_PORT_STD;
    end else if (resdrv_q_ff & ~resdrv) begin
      cdrom_mode_ff <= cdrom_mode_strap; // see RULE16 RULE20
      cfg_port_ff   <= port_select_strap ? `ISH_CFG_PORT_STD
                       : (clock_strap ? `ISH_CFG_PORT_ALT1
                          : `ISH_CFG_PORT_ALT2); // see RULE19
    end
  end

  // Ready flag after the initialization quiet time
  always @(posedge clk) begin
    if (rst) begin
      init_cnt_ff  <= 32'h0;
      dev_ready_ff <= 1'b0;
    end else if (init_cnt_ff >= INIT_CYC - 1) begin
      dev_ready_ff <= 1'b1; // see RULE21
    end else begin
      init_cnt_ff <= init_cnt_ff + 32'h1;
    end
  end

  // Resource maps, defaults restored by reset
  always @(posedge clk) begin
    if (rst) begin
      dma_map_ff <= `ISH_DMA_MAP_RST; // see RULE11
      irq_map_ff <= `ISH_IRQ_MAP_RST; // see RULE14
    end else if (hw_cfg_load) begin
      dma_map_ff <= hw_dma_map;
      irq_map_ff <= hw_irq_map;
    end
  end

  // Cycle sequencer
  always @* begin
    nxt_state = state_ff;
    fifo_push = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (rd_fall & io_hit) begin
          nxt_state = S_RWAIT; // see RULE5
        end else if (rd_fall & dma_cyc) begin
          nxt_state = S_DWAIT;
        end else if (wr_fall & io_hit) begin
          nxt_state = S_HOLD; // see RULE6
        end else if (wr_fall & dma_cyc) begin
          fifo_push = 1'b1;
          nxt_state = fifo_in_ready ? S_HOLD : S_PWAIT;
        end
      end
      S_RWAIT: begin
        if (reg_rdata_valid) begin
          nxt_state = S_HOLD;
        end
      end
      S_DWAIT: begin
        if (dma_rd_valid) begin
          nxt_state = S_HOLD;
        end
      end
      S_PWAIT: begin
        fifo_push = 1'b1;
        if (fifo_in_ready) begin
          nxt_state = S_HOLD;
        end
      end
      S_HOLD: begin
        if (ior_n & iow_n) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  // Sequencer registers, requests and read data
  always @(posedge clk) begin
    if (rst) begin
      state_ff       <= S_IDLE;
      reg_rd_req_ff  <= 1'b0;
      reg_wr_req_ff  <= 1'b0;
      dma_rd_req_ff  <= 1'b0;
      reg_blk_ff     <= 2'h0;
      reg_addr_ff    <= 12'h0;
      reg_wdata_ff   <= 8'h0;
      dma_rd_chan_ff <= 2'h0;
      sd_out_ff      <= 8'h0;
      drive_ff       <= 1'b0;
      wait_ff        <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      reg_rd_req_ff <= (state_ff == S_IDLE) & rd_fall & io_hit;
      reg_wr_req_ff <= (state_ff == S_IDLE) & wr_fall & io_hit & ~rd_fall;
      dma_rd_req_ff <= (state_ff == S_IDLE) & rd_fall & ~io_hit & dma_cyc;
      if ((state_ff == S_IDLE) & (rd_fall | wr_fall)) begin
        reg_blk_ff     <= hit_blk;
        reg_addr_ff    <= sa_low;
        reg_wdata_ff   <= sd_in; // see RULE3
        dma_rd_chan_ff <= ack_ch;
      end
      if ((state_ff == S_RWAIT) & reg_rdata_valid) begin
        sd_out_ff <= reg_rdata;
      end else if ((state_ff == S_DWAIT) & dma_rd_valid) begin
        sd_out_ff <= dma_rd_data; // see RULE12
      end
      drive_ff <= (nxt_state != S_IDLE) & ~ior_n &
                  ((state_ff != S_IDLE) | io_hit | dma_cyc);
      wait_ff  <= (nxt_state == S_RWAIT) | (nxt_state == S_DWAIT) |
                  (nxt_state == S_PWAIT); // see RULE7
    end
  end

  // Per-channel request with byte count of the transfer unit
  always @(posedge clk) begin
    if (rst) begin
      dma_request_lines <= 3'h0;
      need_q_ff         <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        bytes_ff[i] <= 3'h0;
      end
    end else begin
      need_q_ff <= dma_need;
      for (i = 0; i < 3; i = i + 1) begin
        if (~dma_chan_en[i]) begin
          dma_request_lines[i] <= 1'b0;
          bytes_ff[i]          <= 3'h0;
        end else if ((state_ff == S_IDLE) & (rd_fall | wr_fall) &
                     dma_cyc & (ack_ch == i[1:0])) begin
          // One byte moved per acknowledged strobe
          bytes_ff[i] <= bytes_ff[i] - 3'h1; // see RULE10
          dma_request_lines[i] <= (bytes_ff[i] != 3'h1); // see RULE9
        end else if (dma_need[i] & ~need_q_ff[i] &
                     ~dma_request_lines[i]) begin
          bytes_ff[i] <= (dma_unit_bytes[i*3 +: 3] == 3'h0)
                         ? `ISH_XFER_BYTES_RST : dma_unit_bytes[i*3 +: 3];
          dma_request_lines[i] <= 1'b1; // see RULE9
        end
      end
    end
  end

  // DMA write bytes buffered toward the internal consumer
  ish_fifo #(
    .W     (8),
    .DEPTH (FDEPTH),
    .AW    (FAW)
  ) u_wr_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (sd_in), // see RULE12
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (dma_wr_data),
    .out_valid (dma_wr_valid),
    .out_ready (dma_wr_ready)
  );
endmodule

`default_nettype wire

/* core/ish_host_port_regs.vh */
// Constants for the ISA slave host port: reset values, ports, timing
`ifndef ISH_HOST_PORT_REGS_VH
`define ISH_HOST_PORT_REGS_VH

// Default system DMA channel of each pair, 2 bits each {C,B,A}
`define ISH_DMA_MAP_RST   6'h34
// Default system interrupt of each line, 4 bits each {G..A}
`define ISH_IRQ_MAP_RST   28'h0FCB975
// Configuration address port choices
`define ISH_CFG_PORT_STD  12'h279
`define ISH_CFG_PORT_ALT1 12'h308
`define ISH_CFG_PORT_ALT2 12'h388
// Upper address bits that qualify a decode
`define ISH_UPPER_ZERO    4'h0
// Strap reset values (internal pullups read as high)
`define ISH_STRAP_RST     1'b1
// Quiet time after reset drive falls, and the clock rate
`define ISH_INIT_MS       200
`define ISH_CLK_KHZ       100000
`define ISH_INIT_CYC      (`ISH_INIT_MS * `ISH_CLK_KHZ)
// Bytes per transfer unit used when a channel's dma_unit_bytes field is zero
`define ISH_XFER_BYTES_RST 3'h1

`endif

/* sim/ish_asserts.sv */
// Concurrent checks on the ISA slave port's pins
`timescale 1ns/10ps
`default_nettype none
module ish_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        aen,
  input wire logic        ior_n,
  input wire logic [2:0]  dma_ack_lines_n,
  input wire logic        sd_oe,
  input wire logic        iochrdy_oe,
  input wire logic        resdrv,
  input wire logic        buffered_reset_out_n,
  input wire logic        power_down,
  input wire logic [6:0]  irq_lines,
  input wire logic [6:0]  irq_en,
  input wire logic [6:0]  irq_event,
  input wire logic        reg_rd_req_ff,
  input wire logic        reg_wr_req_ff,
  input wire logic [3:0]  upper_address_pins,
  input wire logic        cdrom_mode_ff,
  input wire logic        cdrom_mode_strap,
  input wire logic        port_select_strap,
  input wire logic        clock_strap,
  input wire logic [11:0] cfg_port_ff,
  input wire logic [2:0]  dma_request_lines
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Reset drive handling
  a_bres_low: assert property (buffered_reset_out_n == !resdrv)
    else $error("buffered reset does not follow reset drive");
  a_power_down: assert property (power_down == resdrv)
    else $error("power down does not follow reset drive");
  a_drq_cleared: assert property (resdrv |=> !dma_request_lines)
    else $error("dma request high after reset drive");
  // Straps latched where reset drive falls
  a_port_strap: assert property ($fell(resdrv) |=> cfg_port_ff ==
    ($past(port_select_strap) ? 12'h279 :
     ($past(clock_strap) ? 12'h308 : 12'h388)))
    else $error("config port does not match straps");
  a_mode_strap: assert property ($fell(resdrv) |=>
    cdrom_mode_ff == $past(cdrom_mode_strap))
    else $error("cdrom mode does not match strap");
  // Bus side behaviour
  a_bus_released: assert property (sd_oe |-> !ior_n &&
    (!aen || dma_ack_lines_n != 3'h7))
    else $error("data bus driven outside a read");
  a_irq_gated: assert property (irq_lines == (irq_event & irq_en))
    else $error("interrupt line not gated by its enable");
  a_io_only: assert property ((reg_rd_req_ff || reg_wr_req_ff)
    |-> !$past(aen))
    else $error("register access taken with address enable high");
  a_upper_zero: assert property ((reg_rd_req_ff || reg_wr_req_ff)
    && cdrom_mode_ff |-> $past(upper_address_pins) == 4'h0)
    else $error("register access taken with upper address set");
  a_read_waits: assert property ($rose(reg_rd_req_ff) |-> iochrdy_oe)
    else $error("register read without wait state");
  c_wait: cover property ($rose(iochrdy_oe));
  c_strap: cover property ($fell(resdrv));
  c_write: cover property (reg_wr_req_ff);
endmodule
bind ish_host_port ish_asserts ish_asserts_inst (.clk, .sys_rst, .aen,
  .ior_n, .dma_ack_lines_n, .sd_oe, .iochrdy_oe, .resdrv,
  .buffered_reset_out_n, .power_down,
  .irq_lines, .irq_en, .irq_event, .reg_rd_req_ff, .reg_wr_req_ff,
  .upper_address_pins, .cdrom_mode_ff, .cdrom_mode_strap,
  .port_select_strap, .clock_strap, .cfg_port_ff, .dma_request_lines);
`default_nettype wire

/* sim/ish_host_model.sv */
// Host processor and DMA controller model for the ISA slave port
`timescale 1ns/10ps
`default_nettype none
module ish_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] sd_out,
  input  wire logic       sd_oe,
  input  wire logic       iochrdy_out,
  input  wire logic       iochrdy_oe,
  output logic [11:0]     sa_low,
  output logic            aen,
  output logic            ior_n,
  output logic            iow_n,
  output logic [2:0]      dma_ack_lines_n,
  output logic [7:0]      sd_in
);
  logic [7:0] hd = 8'h00;
  logic       hdrv = 1'b0;
  wire        rdy = iochrdy_oe ? iochrdy_out : 1'b1;
  // Bus level; a released bus shows the inverse of the last byte
  assign sd_in = sd_oe ? sd_out : (hdrv ? hd : ~hd);
  initial begin
    sa_low = 12'h000;
    aen = 1'b0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    dma_ack_lines_n = 3'h7;
  end
  // One strobe cycle: w high writes, a is address enable, k the acks
  task automatic cyc(input logic w, a, input logic [2:0] k,
    input logic [11:0] ad, input logic [7:0] d,
    output logic [7:0] q, output int nw);
    nw = 0;
    @(posedge clk);
    sa_low <= ad;
    aen <= a;
    dma_ack_lines_n <= k;
    hd <= d;
    hdrv <= w;
    ior_n <= w;
    iow_n <= !w;
    repeat (2) @(posedge clk);
    // Stretch while ready is low; pins read as they stand at the edge
    while (!rdy && nw < 300) begin
      nw++;
      @(posedge clk);
    end
    q = sd_in;
    ior_n <= 1'b1;
    iow_n <= 1'b1;
    dma_ack_lines_n <= 3'h7;
    hdrv <= 1'b0;
    sa_low <= ~ad;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Testbench for the ISA slave host port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk, sys_rst, aen, ior_n, iow_n, iochrdy_out, iochrdy_oe;
  logic        sd_oe, resdrv, cdrom_mode_strap, port_select_strap;
  logic        clock_strap, buffered_reset_out_n, power_down, cdrom_mode_ff;
  logic        dev_ready_ff, hw_cfg_load, reg_rd_req_ff, reg_wr_req_ff;
  logic        reg_rdata_valid, dma_rd_req_ff, dma_rd_valid;
  logic        dma_wr_valid, dma_wr_ready;
  logic [1:0]  reg_blk_ff, dma_rd_chan_ff;
  logic [2:0]  dma_request_lines, dma_ack_lines_n, dma_chan_en, dma_need;
  logic [3:0]  upper_address_pins, cfg_blk_en;
  logic [5:0]  hw_dma_map, dma_map_ff;
  logic [6:0]  irq_lines, irq_en, irq_event;
  logic [7:0]  sd_in, sd_out, reg_wdata_ff, reg_rdata, dma_rd_data;
  logic [7:0]  dma_wr_data, q;
  logic [8:0]  dma_unit_bytes;
  logic [11:0] sa_low, cfg_port_ff, reg_addr_ff;
  logic [27:0] hw_irq_map, irq_map_ff;
  logic [47:0] cfg_base;
  int          miscompares, samples_checked, ncyc, cnt, lat, wr_cnt, nw;
  logic [7:0]  got[$];
  ish_host_port #(.INIT_CYC(50)) ish_host_port_inst (.clk, .sys_rst,
    .sa_low, .upper_address_pins, .aen, .ior_n, .iow_n, .sd_in, .sd_out,
    .sd_oe, .iochrdy_out, .iochrdy_oe, .dma_request_lines, .dma_ack_lines_n,
    .irq_lines, .resdrv, .cdrom_mode_strap, .port_select_strap, .clock_strap,
    .buffered_reset_out_n, .power_down, .cdrom_mode_ff, .cfg_port_ff,
    .dev_ready_ff, .cfg_base, .cfg_blk_en, .dma_chan_en, .irq_en, .irq_event,
    .hw_cfg_load, .hw_dma_map, .hw_irq_map, .dma_map_ff, .irq_map_ff,
    .reg_rd_req_ff, .reg_wr_req_ff, .reg_blk_ff, .reg_addr_ff, .reg_wdata_ff,
    .reg_rdata, .reg_rdata_valid, .dma_need, .dma_unit_bytes, .dma_rd_req_ff,
    .dma_rd_chan_ff, .dma_rd_data, .dma_rd_valid, .dma_wr_data,
    .dma_wr_valid, .dma_wr_ready);
  ish_host_model ish_host_model_inst (.clk, .sd_out, .sd_oe, .iochrdy_out,
    .iochrdy_oe, .sa_low, .aen, .ior_n, .iow_n, .dma_ack_lines_n, .sd_in);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Internal read answer lat+1 cycles after a request; write and sink logs
  always @(posedge clk) begin
    if (reg_rd_req_ff || dma_rd_req_ff)
      cnt <= lat;
    else if (cnt != 0)
      cnt <= cnt - 1;
    reg_rdata_valid <= (cnt == 1);
    dma_rd_valid <= (cnt == 1);
    if (reg_wr_req_ff)
      wr_cnt <= wr_cnt + 1;
    if (dma_wr_valid && dma_wr_ready)
      got.push_back(dma_wr_data);
    ncyc <= ncyc + 1;
    if (ncyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [27:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, a, input logic [2:0] k,
    input logic [11:0] ad, input logic [7:0] d);
    ish_host_model_inst.cyc(w, a, k, ad, d, q, nw);
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Reset defaults of maps, port and requests
  task automatic t_reset;
    chk("dma_map", 6'h34, dma_map_ff);
    chk("irq_map", 28'h0FCB975, irq_map_ff);
    chk("cfg_port", 12'h279, cfg_port_ff);
    chk("drq", 3'h0, dma_request_lines);
  endtask
  // Each strap setting latched as reset drive falls
  task automatic t_straps;
    logic [11:0] pt [3] = '{12'h308, 12'h388, 12'h279};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      port_select_strap <= (i == 2);
      clock_strap <= (i == 0);
      cdrom_mode_strap <= (i != 0);
      resdrv <= 1'b1;
      repeat (3) tick();
      chk("bres_n", 1'b0, buffered_reset_out_n);
      chk("power_down", 1'b1, power_down);
      @(posedge clk);
      resdrv <= 1'b0;
      repeat (2) tick();
      chk("cfg_port", pt[i], cfg_port_ff);
      chk("cdrom_mode", i != 0, cdrom_mode_ff);
      chk("ready_early", 1'b0, dev_ready_ff);
      repeat (60) tick();
      chk("ready", 1'b1, dev_ready_ff);
    end
  endtask
  // Writes: one hit, then aen high, upper bits set and unmapped
  task automatic t_io_wr;
    int n;
    n = wr_cnt;
    bus(1, 0, 3'h7, 12'h335, 8'h5A);
    chk("wr_blk", 2'h1, reg_blk_ff);
    chk("wr_addr", 12'h335, reg_addr_ff);
    chk("wr_data", 8'h5A, reg_wdata_ff);
    chk("wr_wait", 1'b0, nw > 0);
    bus(1, 1, 3'h7, 12'h335, 8'h11);
    upper_address_pins <= 4'h2;
    bus(1, 0, 3'h7, 12'h335, 8'h22);
    upper_address_pins <= 4'h0;
    bus(1, 0, 3'h7, 12'h7F0, 8'h33);
    chk("wr_count", n + 1, wr_cnt);
  endtask
  // Reads with quick and slow internal answers
  task automatic t_io_rd;
    for (int i = 1; i < 8; i += 6) begin
      lat = i;
      reg_rdata <= 8'hA0 + i[7:0];
      bus(0, 0, 3'h7, 12'h22C, 8'h00);
      chk("rd_data", 8'hA0 + i[7:0], q);
      chk("rd_wait", 1'b1, nw > 0);
      chk("rd_blk", 2'h0, reg_blk_ff);
      chk("sd_oe", 1'b0, sd_oe);
    end
  endtask
  // DMA writes into a stalled FIFO, units of four bytes
  task automatic t_dma_wr;
    dma_wr_ready <= 1'b0;
    got.delete();
    for (int i = 0; i < 9; i++) begin
      if (i % 4 == 0) begin
        dma_need[0] <= 1'b0;
        @(posedge clk);
        dma_need[0] <= 1'b1;
        repeat (2) tick();
      end
      chk("drq_a_up", 1'b1, dma_request_lines[0]);
      if (i == 8)
        fork
          begin
            repeat (20) @(posedge clk);
            dma_wr_ready <= 1'b1;
          end
        join_none
      bus(1, 1, 3'h6, 12'h000, 8'h40 + i[7:0]);
      chk("full_wait", i == 8, nw > 0);
      chk("drq_a", i % 4 != 3, dma_request_lines[0]);
    end
    repeat (20) tick();
    chk("sink_count", 9, got.size());
    for (int i = 0; i < 9; i++)
      chk("sink_byte", 8'h40 + i[7:0], got[i]);
    @(posedge clk);
    dma_need[0] <= 1'b0;
  endtask
  // DMA read on the second pair
  task automatic t_dma_rd;
    dma_need[1] <= 1'b1;
    repeat (2) tick();
    lat = 3;
    dma_rd_data <= 8'h9C;
    bus(0, 1, 3'h5, 12'h000, 8'h00);
    chk("dma_rd", 8'h9C, q);
    chk("dma_chan", 2'h1, dma_rd_chan_ff);
    chk("drq_b", 1'b0, dma_request_lines[1]);
  endtask
  // Interrupt gating and map load
  task automatic t_irq_map;
    irq_event <= 7'h7F;
    irq_en <= 7'h55;
    tick();
    chk("irq", 7'h55, irq_lines);
    @(posedge clk);
    hw_dma_map <= 6'h1B;
    hw_irq_map <= 28'h0A0B0C1;
    hw_cfg_load <= 1'b1;
    @(posedge clk);
    hw_cfg_load <= 1'b0;
    tick();
    chk("dma_map_ld", 6'h1B, dma_map_ff);
    chk("irq_map_ld", 28'h0A0B0C1, irq_map_ff);
  endtask
  initial begin
    {sys_rst, cdrom_mode_strap, port_select_strap, clock_strap} = 4'hF;
    {resdrv, hw_cfg_load, reg_rdata_valid, dma_rd_valid} = 4'h8;
    dma_wr_ready = 1'b1;
    upper_address_pins = 4'h0;
    cfg_base = 48'h600530330220;
    cfg_blk_en = 4'hF;
    dma_chan_en = 3'h7;
    {irq_en, irq_event, dma_need} = 17'h00000;
    {hw_dma_map, hw_irq_map} = 34'h000000000;
    {reg_rdata, dma_rd_data} = 16'h0000;
    dma_unit_bytes = 9'h08C;
    {cnt, wr_cnt, ncyc, miscompares, samples_checked} = '0;
    lat = 1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    resdrv <= 1'b0;
    repeat (2) tick();
    t_reset();
    t_straps();
    t_io_wr();
    t_io_rd();
    t_dma_wr();
    t_dma_rd();
    t_irq_map();
    close_out();
  end
endmodule
`default_nettype wire
